// ==== sim/fan_model.sv ====
// behavioural fan rotor and current-sense pulse source
`timescale 1ns/10ps
module fan_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench controls and drive from the supervisor
    input wire logic spin,
    input wire logic glitch,
    input wire logic drive,
    // sense pulse
    output logic pulse
);
    logic [8:0] cnt_r;
    logic drive_q_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 9'h000;
            drive_q_r <= 1'b0;
        end else begin
            cnt_r <= (cnt_r == 9'h12b) ? 9'h000 : cnt_r + 9'h001;
            drive_q_r <= drive;
        end
    end
    // a stalled rotor still chops the current when the switch closes
    assign pulse = (spin && cnt_r < 9'h002) || (glitch && drive && !drive_q_r);
endmodule : fan_model

// ==== sim/testbench.sv ====
// self-checking bench for the fan pwm supervisor
`timescale 1ns/10ps
module testbench;
    import fan_pkg::*;
    localparam int PER = 512;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] level = 8'h40;
    logic halt_lo = 1'b0;
    logic rel_hi = 1'b1;
    logic auto_lo = 1'b0;
    logic hyst_hi = 1'b1;
    logic full_hi = 1'b0;
    logic spin = 1'b0;
    logic glitch = 1'b1;
    logic rot_pulse;
    logic fan_drive_out;
    logic alarm_n;
    logic [31:0] rd;
    logic er;
    logic [7:0] lvls [3] = '{8'h00, 8'h40, 8'hc8};
    int hi;
    int err_count = 0;
    int checks = 0;

    fan_pwm_fault_supervisor #(.STEP_DIV_P(2)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .temperature_level_in(level), .below_halt_threshold(halt_lo),
        .above_release_threshold(rel_hi), .below_auto_off_threshold(auto_lo),
        .above_auto_off_hysteresis(hyst_hi), .above_full_duty_level(full_hi),
        .rot_pulse(rot_pulse), .fan_drive_out(fan_drive_out), .alarm_n(alarm_n)
    );
    fan_model i_fan (.pclk(pclk), .presetn(presetn), .spin(spin), .glitch(glitch),
        .drive(fan_drive_out), .pulse(rot_pulse));

    always #50 pclk = ~pclk;

    // ********************
    // tasks
    // ********************
    task automatic results;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    task automatic cyc(input int n);
        repeat (n) @(negedge pclk);
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, pready}, 32'h1, "apb answer");
        if (pready !== 1'b1) results();
    endtask : apb
    task automatic chk_pin(input logic d, input logic a, input string what);
        @(negedge pclk);
        chk({30'h0, fan_drive_out, alarm_n}, {30'h0, d, a}, what);
    endtask : chk_pin
    task automatic chk_st(input state_t s, input string what);
        apb(1'b0, STATUS_OFS, WORD_ZERO);
        chk({29'h0, rd[ST_STATE_LSB +: 3]}, {29'h0, s}, what);
    endtask : chk_st
    // bounded poll; running out of cycles ends the run
    task automatic wait_st(input state_t s, input int lim, input string what);
        int n;
        n = 0;
        do begin
            apb(1'b0, STATUS_OFS, WORD_ZERO);
            n += 3;
        end while (rd[ST_STATE_LSB +: 3] !== s && n < lim);
        chk({29'h0, rd[ST_STATE_LSB +: 3]}, {29'h0, s}, what);
        if (rd[ST_STATE_LSB +: 3] !== s) results();
    endtask : wait_st

    // ********************
    // main sequence
    // ********************
    initial begin
        chk_pin(1'b0, 1'b1, "in reset");
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        cyc(2);
        chk_pin(1'b1, 1'b1, "power-up drive");
        apb(1'b0, CTRL_OFS, WORD_ZERO);
        chk(rd, WORD_ZERO, "ctrl reset");
        apb(1'b0, 12'h00c, WORD_ZERO);
        chk({rd[30:0], er}, 32'h1, "unmapped");
        chk_st(ST_START1, "start1");
        // stalled rotor: only switch-on chops reach the sense input
        cyc(30 * PER);
        chk_st(ST_START1, "start1 hold");
        wait_st(ST_START2, 3 * PER, "second start");
        chk_pin(1'b1, 1'b1, "second start drive");
        wait_st(ST_FAULT, 34 * PER, "power-up fail");
        chk_pin(1'b0, 1'b0, "fail pins");
        @(posedge pclk);
        auto_lo <= 1'b1;
        hyst_hi <= 1'b0;
        cyc(PER);
        chk_st(ST_FAULT, "latched");
        @(posedge pclk);
        halt_lo <= 1'b1;
        rel_hi <= 1'b0;
        full_hi <= 1'b1;
        cyc(4);
        chk_pin(1'b0, 1'b1, "halt pins");
        chk_st(ST_HALT, "halt");
        chk({31'h0, rd[ST_FAIL_BIT]}, 32'h0, "fail cleared");
        apb(1'b0, TIMER_OFS, WORD_ZERO);
        chk(rd, WORD_ZERO, "halt timer");
        @(posedge pclk);
        halt_lo <= 1'b0;
        rel_hi <= 1'b1;
        cyc(4);
        chk_st(ST_AUTO, "release low");
        chk_pin(1'b0, 1'b1, "auto pins");
        @(posedge pclk);
        auto_lo <= 1'b0;
        full_hi <= 1'b0;
        cyc(PER);
        chk_st(ST_AUTO, "in hysteresis");
        @(posedge pclk);
        hyst_hi <= 1'b1;
        cyc(4);
        chk_st(ST_START1, "auto exit");
        @(posedge pclk);
        spin <= 1'b1;
        wait_st(ST_RUN, PER, "rotation");
        foreach (lvls[i]) begin
            @(posedge pclk);
            level <= lvls[i];
            cyc(PER + 8);
            hi = 0;
            repeat (PER) begin
                @(negedge pclk);
                if (fan_drive_out === 1'b1) hi++;
            end
            chk(hi, {23'h0, lvls[i], 1'b0}, "duty");
        end
        @(posedge pclk);
        full_hi <= 1'b1;
        cyc(4);
        chk_pin(1'b1, 1'b0, "overheat");
        @(posedge pclk);
        full_hi <= 1'b0;
        cyc(4);
        chk({31'h0, alarm_n}, 32'h1, "warning clear");
        @(posedge pclk);
        auto_lo <= 1'b1;
        hyst_hi <= 1'b0;
        cyc(4);
        chk_pin(1'b0, 1'b1, "auto-off");
        @(posedge pclk);
        auto_lo <= 1'b0;
        hyst_hi <= 1'b1;
        wait_st(ST_RUN, 2 * PER, "auto restart");
        apb(1'b1, CTRL_OFS, 32'h0000_0001);
        cyc(4);
        chk_st(ST_HALT, "soft halt");
        apb(1'b1, CTRL_OFS, WORD_ZERO);
        chk_st(ST_START1, "soft release");
        wait_st(ST_RUN, PER, "run again");
        // rotor stops; switch-on chops keep arriving and must stay blanked
        @(posedge pclk);
        spin <= 1'b0;
        cyc(29 * PER);
        chk_st(ST_RUN, "miss count");
        wait_st(ST_DIAG, 4 * PER, "diag entry");
        cyc(PER);
        chk_st(ST_DIAG, "diag hold");
        chk_pin(1'b1, 1'b1, "diag drive");
        wait_st(ST_RETRY, 3 * PER, "retry");
        chk_pin(1'b1, 1'b1, "retry drive");
        wait_st(ST_FAULT, 34 * PER, "run fail");
        chk_pin(1'b0, 1'b0, "run fail pins");
        results();
    end
endmodule : testbench

// ==== src/fan_pkg.sv ====
// shared constants, register map and state type of the fan supervisor
package fan_pkg;
    // clock and pwm rate
    localparam int CLK_HZ = 10_000_000;
    localparam int PWM_HZ = 30;
    localparam int LEVEL_W = 8;
    localparam int PWM_STEPS = 1 << LEVEL_W;
    localparam int STEP_DIV = CLK_HZ / (PWM_HZ * PWM_STEPS);
    // timers, counted in pwm periods
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] START_LAST = 6'h1f;
    localparam logic [CNT_W-1:0] MISS_LAST = 6'h1f;
    localparam logic [CNT_W-1:0] DIAG_LAST = 6'h02;
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    // rotation pulse blanking after the drive switches on, in clocks
    localparam int BLANK_W = 8;
    localparam logic [BLANK_W-1:0] BLANK_CLKS = 8'h40;
    localparam logic [BLANK_W-1:0] BLANK_ONE = 8'h01;
    localparam logic [BLANK_W-1:0] BLANK_ZERO = 8'h00;
    // register map
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
    localparam logic [ADDR_W-1:0] TIMER_OFS = 12'h008;
    localparam int CTRL_HALT_BIT = 0;
    localparam int ST_DRIVE_BIT = 0;
    localparam int ST_ALARM_BIT = 1;
    localparam int ST_FULL_BIT = 2;
    localparam int ST_FAIL_BIT = 3;
    localparam int ST_STATE_LSB = 4;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    // control states
    typedef enum logic [2:0] {
        ST_HALT,
        ST_AUTO,
        ST_START1,
        ST_START2,
        ST_RUN,
        ST_DIAG,
        ST_RETRY,
        ST_FAULT
    } state_t;
endpackage : fan_pkg

// ==== src/fan_pwm_fault_supervisor.sv ====
// fan pwm drive with start-up, diagnostic and missing-pulse supervision
// Summary of operation
// - duty follows temperature level, zero to full
// - drive output is active high
// - alarm output is active low
// - start-up holds drive on 32 periods
// - start-up after reset, halt and auto-off
// - pulses at drive switch-on are blanked
// - 32 periods without pulse start diagnostic
// - diagnostic drives full on three periods
// - no pulse in diagnostic retries start-up
// - second timeout stops drive, alarm low
// - failure stays latched until reset sequence
// - halt then release clears the failure
// - full duty demand pulls alarm low
// - overheat warning does not latch
// - below auto-off threshold enters auto-shutdown
// - leave auto-shutdown above threshold plus hysteresis
// - alarm high in halt and auto-shutdown
// - below halt threshold stops everything
// - entering halt clears timers and failures
// - release starts fan if above hysteresis
// - release below auto-off goes to auto-shutdown
// - valid pulse restarts missing-pulse count
// - power-up retries start-up once, then fails
`timescale 1ns/10ps
module fan_pwm_fault_supervisor
    import fan_pkg::*;
#(
    parameter int STEP_DIV_P = fan_pkg::STEP_DIV
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fan_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // comparator results and digitised temperature
    input wire logic [fan_pkg::LEVEL_W-1:0] temperature_level_in,
    input wire logic below_halt_threshold,
    input wire logic above_release_threshold,
    input wire logic below_auto_off_threshold,
    input wire logic above_auto_off_hysteresis,
    input wire logic above_full_duty_level,
    // fan side
    input wire logic rot_pulse,
    output logic fan_drive_out,
    output logic alarm_n
);
    import fan_pkg::*;

    // ****************************************
    // time base
    // ****************************************
    logic [LEVEL_W-1:0] step;
    logic tick;

    pwm_timebase #(
        .STEP_DIV(STEP_DIV_P),
        .LEVEL_W(LEVEL_W)
    ) u_timebase (
        .pclk(pclk),
        .presetn(presetn),
        .step(step),
        .tick(tick)
    );

    // ****************************************
    // state
    // ****************************************
    state_t state_r;
    state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic drive_r;
    logic alarm_n_r;
    logic rot_prev_r;
    logic [BLANK_W-1:0] blank_r;
    logic [BLANK_W-1:0] blank_nxt;
    logic halt_sw_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // comparator inputs are used directly: they arrive synchronous
    wire halt_req = below_halt_threshold || halt_sw_r;
    wire full_duty = above_full_duty_level || (&temperature_level_in);
    wire pulse_edge = rot_pulse && !rot_prev_r;
    wire blanked = (blank_r != BLANK_ZERO);
    // switch-on transients on the sense line are not rotation
    wire pulse_ok = pulse_edge && !blanked;
    wire timer_end_start = tick && (cnt_r == START_LAST);
    wire timer_end_miss = tick && (cnt_r == MISS_LAST);
    wire timer_end_diag = tick && (cnt_r == DIAG_LAST);
    wire [CNT_W-1:0] cnt_inc = tick ? cnt_r + CNT_ONE : cnt_r;
    wire fan_active = (state_r == ST_START1) || (state_r == ST_START2) || (state_r == ST_RUN)
        || (state_r == ST_DIAG) || (state_r == ST_RETRY);

    // ****************************************
    // control sequence
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_HALT: begin
                if (!halt_req && above_release_threshold) begin
                    // release: start only with clear margin above auto-off
                    state_nxt = above_auto_off_hysteresis ? ST_START1 : ST_AUTO;
                end
            end
            ST_AUTO: begin
                if (above_auto_off_hysteresis) begin
                    state_nxt = ST_START1;
                end
            end
            ST_START1: begin
                if (pulse_ok) begin
                    state_nxt = ST_RUN;
                end else if (timer_end_start) begin
                    state_nxt = ST_START2;
                end
            end
            ST_START2: begin
                if (pulse_ok) begin
                    state_nxt = ST_RUN;
                end else if (timer_end_start) begin
                    state_nxt = ST_FAULT;
                end
            end
            ST_RUN: begin
                if (!pulse_ok && timer_end_miss) begin
                    state_nxt = ST_DIAG;
                end
            end
            ST_DIAG: begin
                if (pulse_ok) begin
                    state_nxt = ST_RUN;
                end else if (timer_end_diag) begin
                    state_nxt = ST_RETRY;
                end
            end
            ST_RETRY: begin
                if (pulse_ok) begin
                    state_nxt = ST_RUN;
                end else if (timer_end_miss) begin
                    state_nxt = ST_FAULT;
                end
            end
            ST_FAULT: begin
                state_nxt = ST_FAULT;
            end
            default: begin
                state_nxt = ST_HALT;
            end
        endcase
        // a latched failure ignores auto-off: only a halt releases it
        if (halt_req) begin
            state_nxt = ST_HALT;
        end else if (below_auto_off_threshold && fan_active) begin
            state_nxt = ST_AUTO;
        end
    end

    always_comb begin
        cnt_nxt = cnt_inc;
        // halt stops every timer, not only the one that was running on entry
        if (state_nxt != state_r || state_nxt == ST_HALT) begin
            cnt_nxt = CNT_ZERO;
        end else if (state_r == ST_RUN && pulse_ok) begin
            cnt_nxt = CNT_ZERO;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // forced-on states give the fan full torque regardless of level
    wire forced_on = (state_nxt == ST_START1) || (state_nxt == ST_START2)
        || (state_nxt == ST_DIAG) || (state_nxt == ST_RETRY);
    wire pwm_on = full_duty || (step < temperature_level_in);
    wire drive_nxt = forced_on || (state_nxt == ST_RUN && pwm_on);
    wire warn_ok = forced_on || (state_nxt == ST_RUN);
    // warning tracks the demand each cycle, only failure latches
    wire alarm_n_nxt = !((state_nxt == ST_FAULT) || (warn_ok && full_duty));

    always_comb begin
        blank_nxt = blanked ? blank_r - BLANK_ONE : BLANK_ZERO;
        if (drive_nxt && !drive_r) begin
            blank_nxt = BLANK_CLKS;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_START1;
            cnt_r <= CNT_ZERO;
            drive_r <= 1'b0;
            alarm_n_r <= 1'b1;
            rot_prev_r <= 1'b0;
            blank_r <= BLANK_ZERO;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            drive_r <= drive_nxt;
            alarm_n_r <= alarm_n_nxt;
            rot_prev_r <= rot_pulse;
            blank_r <= blank_nxt;
        end
    end

    assign fan_drive_out = drive_r;
    assign alarm_n = alarm_n_r;

    // ****************************************
    // apb registers
    // ****************************************
    // zero wait: data is fetched in the setup cycle so pready can rise at once
    wire apb_setup = psel && !penable;
    wire apb_write = psel && penable && pready_r && pwrite;
    wire hit_ctrl = (paddr == CTRL_OFS);
    wire hit_status = (paddr == STATUS_OFS);
    wire hit_timer = (paddr == TIMER_OFS);
    wire addr_hit = hit_ctrl || hit_status || hit_timer;
    wire [31:0] ctrl_word = {31'h0000_0000, halt_sw_r};
    wire [31:0] status_word = {25'h000_0000, state_r, (state_r == ST_FAULT), full_duty, alarm_n_r, drive_r};
    wire [31:0] timer_word = {26'h000_0000, cnt_r};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_word : hit_status ? status_word : hit_timer ? timer_word : WORD_ZERO;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= WORD_ZERO;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            halt_sw_r <= 1'b0;
        end else begin
            pready_r <= apb_setup;
            pslverr_r <= apb_setup && !addr_hit;
            if (apb_setup) begin
                prdata_r <= rd_mux;
            end
            if (apb_write && hit_ctrl) begin
                halt_sw_r <= pwdata[CTRL_HALT_BIT];
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_alarm_idle_high: assert property (
        (state_r == ST_HALT || state_r == ST_AUTO) |-> alarm_n
    ) else $error("alarm active in halt or auto-off");

    a_fault_latched_out: assert property (
        (state_r == ST_FAULT) |-> (!fan_drive_out && !alarm_n)
    ) else $error("failure state without drive off and alarm low");

    a_fault_holds: assert property (
        (state_r == ST_FAULT && !halt_req) |=> (state_r == ST_FAULT)
    ) else $error("failure left without halt");

    a_halt_clears: assert property (
        halt_req |=> (state_r == ST_HALT && cnt_r == CNT_ZERO && !fan_drive_out)
    ) else $error("halt did not reset state and timer");

    // the reset state leads the registered drive by one edge, so skip the release edges
    a_start_forced_on: assert property (
        $past(presetn) && (state_r == ST_START1 || state_r == ST_START2 || state_r == ST_DIAG) |-> fan_drive_out
    ) else $error("drive off during forced period");

    a_start_retry: assert property (
        (state_r == ST_START1 && timer_end_start && !pulse_ok && !halt_req && !below_auto_off_threshold)
        |=> (state_r == ST_START2)
    ) else $error("first start-up timeout did not retry");

    a_miss_to_diag: assert property (
        (state_r == ST_RUN && timer_end_miss && !pulse_ok && !halt_req && !below_auto_off_threshold)
        |=> (state_r == ST_DIAG && fan_drive_out)
    ) else $error("missing pulse timeout did not start diagnostic");

    a_pulse_restart: assert property (
        (state_r == ST_RUN && pulse_ok && !halt_req && !below_auto_off_threshold) |=> (cnt_r == CNT_ZERO)
    ) else $error("valid pulse did not restart missing-pulse count");

    a_warn_follows: assert property (
        (state_r == ST_RUN && $past(state_r) == ST_RUN) |-> (alarm_n == !$past(full_duty))
    ) else $error("overheat warning does not follow full duty");

    a_auto_entry: assert property (
        (fan_active && below_auto_off_threshold && !halt_req) |=> (state_r == ST_AUTO && !fan_drive_out)
    ) else $error("auto-off not entered");

    a_blank_pulse: assert property (
        (state_r == ST_DIAG && $rose(fan_drive_out) && pulse_edge) |=> (state_r != ST_RUN)
    ) else $error("switch-on pulse accepted");

    a_release_auto: assert property (
        (state_r == ST_HALT && !halt_req && above_release_threshold && !above_auto_off_hysteresis)
        |=> (state_r == ST_AUTO && !fan_drive_out)
    ) else $error("release below hysteresis did not enter auto-off");

    a_release_start: assert property (
        (state_r == ST_HALT && !halt_req && above_release_threshold && above_auto_off_hysteresis)
        |=> (state_r == ST_START1 && fan_drive_out)
    ) else $error("release above hysteresis did not start the fan");

    a_auto_exit: assert property (
        (state_r == ST_AUTO && above_auto_off_hysteresis && !halt_req) |=> (state_r == ST_START1 && fan_drive_out)
    ) else $error("auto-off exit did not start the fan");

    a_auto_holds: assert property (
        (state_r == ST_AUTO && !above_auto_off_hysteresis && !halt_req) |=> (state_r == ST_AUTO)
    ) else $error("auto-off left inside hysteresis");

    a_diag_retry: assert property (
        (state_r == ST_DIAG && timer_end_diag && !pulse_ok && !halt_req && !below_auto_off_threshold)
        |=> (state_r == ST_RETRY && fan_drive_out)
    ) else $error("diagnostic timeout did not retry start-up");

    a_retry_fault: assert property (
        (state_r == ST_RETRY && timer_end_miss && !pulse_ok && !halt_req && !below_auto_off_threshold)
        |=> (state_r == ST_FAULT)
    ) else $error("second timeout did not latch failure");

    a_full_drive: assert property (
        (state_r == ST_RUN && $past(above_full_duty_level)) |-> fan_drive_out
    ) else $error("full duty demand without drive");

    a_zero_duty: assert property (
        (state_r == ST_RUN && $past(temperature_level_in) == '0 && !$past(above_full_duty_level)) |-> !fan_drive_out
    ) else $error("drive on at zero level");
endmodule : fan_pwm_fault_supervisor

// ==== src/pwm_timebase.sv ====
// pwm step counter and one-cycle period tick derived from the system clock
`timescale 1ns/10ps
module pwm_timebase #(
    parameter int STEP_DIV = 1302,
    parameter int LEVEL_W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // time base
    output logic [LEVEL_W-1:0] step,
    output logic tick
);
    localparam int DIV_W = $clog2(STEP_DIV + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_ZERO = '0;

    logic [DIV_W-1:0] div_r;
    logic [LEVEL_W-1:0] step_r;
    logic tick_r;
    wire step_en = (div_r == DIV_LAST);
    wire period_end = step_en && (&step_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= '0;
            step_r <= '0;
            tick_r <= 1'b0;
        end else begin
            div_r <= step_en ? DIV_ZERO : div_r + 1'b1;
            if (step_en) begin
                step_r <= step_r + 1'b1;
            end
            tick_r <= period_end;
        end
    end

    assign step = step_r;
    assign tick = tick_r;
endmodule : pwm_timebase
